// file: inc/mcl_pkg.sv
/*
 mcl_pkg: constants for the modem control line logic.
 assumes a 100 MHz core clock.
*/
package mcl_pkg;
   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned DROP_MS      = 67;
   localparam int unsigned DROP_CYCLES  = DROP_MS * 1000 * CLK_MHZ;
   localparam int unsigned DROP_W       = 23;
   localparam logic [6:0]  CODE_EOT     = 7'h04;
   localparam logic [6:0]  CODE_DLE     = 7'h10;
   localparam logic [6:0]  CODE_QMARK   = 7'h3f;
   localparam logic [6:0]  TURN_RST     = 7'h11;
   localparam logic [3:0]  ADR_CTRL     = 4'h0;
   localparam logic [3:0]  ADR_TURN     = 4'h1;
   localparam logic [3:0]  ADR_STAT     = 4'h2;
   localparam int unsigned CTRL_LINE    = 0;
   localparam int unsigned CTRL_EOTDIS  = 1;
   localparam int unsigned CTRL_TRANSP  = 2;
endpackage : mcl_pkg

// file: rtl/mcl_sync.sv
/*
 mcl_sync: two-flop synchroniser for asynchronous level inputs.
 assumes inputs are quasi-static panel and line levels.
*/
`timescale 1ns/1ns
`default_nettype none
module mcl_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         sys_rst,
   // levels
   input  wire logic [W-1:0] async_i,
   output var  logic [W-1:0] sync_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } mcl_sync_t;
   mcl_sync_t st_q, st_d;
   always_comb begin
      st_d    = st_q;
      st_d.s1 = async_i;
      st_d.s2 = st_q.s1;
   end
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign sync_o = st_q.s2;
endmodule : mcl_sync
`default_nettype wire

// file: rtl/mcl_drop_timer.sv
/*
 mcl_drop_timer: times the forced-disconnect drop of terminal ready.
 assumes start is a one-cycle pulse from the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module mcl_drop_timer
   import mcl_pkg::*;
#(
   parameter int unsigned CYCLES = DROP_CYCLES
) (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic sys_rst,
   // control
   input  wire logic start,
   output var  logic busy
);
   typedef struct packed {
      logic [DROP_W-1:0] cnt;
      logic              busy;
   } mcl_tmr_t;
   mcl_tmr_t st_q, st_d;
   always_comb begin
      st_d = st_q;
      if (start) begin
         st_d.cnt  = DROP_W'(CYCLES - 1);
         st_d.busy = 1'b1;
      end else if (st_q.busy) begin
         if (st_q.cnt == '0) begin
            st_d.busy = 1'b0;
         end else begin
            st_d.cnt = st_q.cnt - 1'b1;
         end
      end
   end
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign busy = st_q.busy;
endmodule : mcl_drop_timer
`default_nettype wire

// file: rtl/mcl_top.sv
/*
 mcl_top: terminal-side modem control line logic.
 assumes rx/tx code strobes come from the core clock domain; panel and
 line levels are asynchronous and synchronised here.
*/
// Contract
// - transparency on: no print, no control action
// - idle transmit line stays at mark
// - on-line button asserts request to send
// - line control: DLE ? or turnaround asserts
// - low voltage, standby, local drop request
// - EOT drops request unless strapped off or after DLE
// - line control: sent turnaround drops request
// - ready lamp follows clear, unless interrupt lit
// - line control: turnaround received masks clear
// - terminal ready off: power, local, paper
// - line control: DLE EOT drops ready 67 ms
// - terminal ready on otherwise
`timescale 1ns/1ns
`default_nettype none
module mcl_top
   import mcl_pkg::*;
#(
   parameter int unsigned DROP_CYC = DROP_CYCLES
) (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   // register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output var  logic [7:0] reg_rdata,
   // panel levels, asynchronous
   input  wire logic       btn_online,
   input  wire logic       btn_standby,
   input  wire logic       btn_local,
   input  wire logic       low_voltage,
   input  wire logic       power_ok,
   input  wire logic       low_paper,
   input  wire logic       interrupt_lamp,
   // modem line, asynchronous
   input  wire logic       clear_to_send,
   // code streams, same clock
   input  wire logic       rx_valid,
   input  wire logic [6:0] rx_code,
   input  wire logic       tx_valid,
   input  wire logic [6:0] tx_code,
   input  wire logic       tx_serial,
   // outputs
   output var  logic       tx_line,
   output var  logic       request_to_send,
   output var  logic       terminal_ready,
   output var  logic       ready_lamp,
   output var  logic       print_en,
   output var  logic       ctrl_en,
   output var  logic       tape_valid,
   output var  logic [6:0] tape_code
);
   typedef struct packed {
      logic       line_opt;
      logic       eot_dis;
      logic       transp;
      logic [6:0] turn_chr;
      logic       dle_seen;
      logic       cts_mask;
      logic       paper_lat;
      logic       rts;
      logic       dtr;
      logic       txl;
      logic       lamp;
      logic       pen;
      logic       cen;
      logic       tv;
      logic [6:0] tc;
      logic [7:0] rdata;
   } mcl_st_t;

   localparam int unsigned NSYNC = 8;
   logic [NSYNC-1:0] sy;
   logic             s_onl, s_stb, s_loc, s_lv, s_pwr, s_pap, s_int, s_cts;
   logic             drop_start, drop_busy;
   mcl_st_t          st_q, st_d;

   mcl_sync #(.W(NSYNC)) u_sync (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .async_i  ({btn_online, btn_standby, btn_local, low_voltage,
                  power_ok, low_paper, interrupt_lamp, clear_to_send}),
      .sync_o   (sy)
   );
   assign {s_onl, s_stb, s_loc, s_lv, s_pwr, s_pap, s_int, s_cts} = sy;

   mcl_drop_timer #(.CYCLES(DROP_CYC)) u_tmr (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .start    (drop_start),
      .busy     (drop_busy)
   );

   function automatic logic is_code(input logic v, input logic [6:0] c,
                                    input logic [6:0] k);
      is_code = v && (c == k);
   endfunction : is_code

   logic rx_act, cts_eff;
   always_comb begin
      st_d       = st_q;
      drop_start = 1'b0;
      // received control codes only act while transparency is off
      rx_act     = rx_valid && !st_q.transp;
      // register port
      if (reg_wr && reg_addr == ADR_CTRL) begin
         st_d.line_opt = reg_wdata[CTRL_LINE];
         st_d.eot_dis  = reg_wdata[CTRL_EOTDIS];
         st_d.transp   = reg_wdata[CTRL_TRANSP];
      end
      if (reg_wr && reg_addr == ADR_TURN) begin
         st_d.turn_chr = reg_wdata[6:0];
      end
      st_d.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            ADR_CTRL: st_d.rdata = {5'h00, st_q.transp, st_q.eot_dis,
                                    st_q.line_opt};
            ADR_TURN: st_d.rdata = {1'b0, st_q.turn_chr};
            ADR_STAT: st_d.rdata = {2'h0, drop_busy, st_q.paper_lat,
                                    st_q.cts_mask, s_cts, st_q.dtr,
                                    st_q.rts};
            default:  st_d.rdata = 8'h00;
         endcase
      end
      // DLE prefix tracking
      if (rx_act) begin
         st_d.dle_seen = (rx_code == CODE_DLE);
      end
      // request to send: off wins over on
      if (s_onl) begin
         st_d.rts = 1'b1;
      end
      if (st_q.line_opt && rx_act &&
          ((st_q.dle_seen && rx_code == CODE_QMARK) ||
           rx_code == st_q.turn_chr)) begin
         st_d.rts = 1'b1;
      end
      if (is_code(rx_act, rx_code, CODE_EOT) && !st_q.eot_dis &&
          !st_q.dle_seen) begin
         st_d.rts = 1'b0;
      end
      if (st_q.line_opt && is_code(tx_valid, tx_code, st_q.turn_chr)) begin
         st_d.rts = 1'b0;
      end
      if (s_lv || s_stb || s_loc) begin
         st_d.rts = 1'b0;
      end
      // clear to send masking by turnaround, freed when clear drops
      if (!s_cts) begin
         st_d.cts_mask = 1'b0;
      end
      if (st_q.line_opt && is_code(rx_act, rx_code, st_q.turn_chr)) begin
         st_d.cts_mask = 1'b1;
      end
      cts_eff = s_cts && !st_q.cts_mask;
      st_d.lamp = cts_eff && !s_int;
      // low paper with clear off latches until paper restored
      if (!s_pap) begin
         st_d.paper_lat = 1'b0;
      end else if (!cts_eff) begin
         st_d.paper_lat = 1'b1;
      end
      if (st_q.line_opt && st_q.dle_seen &&
          is_code(rx_act, rx_code, CODE_EOT)) begin
         drop_start = 1'b1;
      end
      st_d.dtr = !(!s_pwr || s_loc || st_q.paper_lat ||
                   drop_busy || drop_start);
      st_d.txl = tx_valid ? tx_serial : 1'b1;
      st_d.pen = !st_q.transp;
      st_d.cen = !st_q.transp;
      st_d.tv  = rx_valid;
      st_d.tc  = rx_code;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_q          <= '0;
         st_q.turn_chr <= TURN_RST;
         st_q.txl      <= 1'b1;
         st_q.pen      <= 1'b1;
         st_q.cen      <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata       = st_q.rdata;
   assign tx_line         = st_q.txl;
   assign request_to_send = st_q.rts;
   assign terminal_ready  = st_q.dtr;
   assign ready_lamp      = st_q.lamp;
   assign print_en        = st_q.pen;
   assign ctrl_en         = st_q.cen;
   assign tape_valid      = st_q.tv;
   assign tape_code       = st_q.tc;

   // transmit line
   a_idle_mark: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      !tx_valid |=> tx_line)
      else $error("tx not mark when idle");
   a_tx_follow: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      tx_valid |=> tx_line == $past(tx_serial))
      else $error("tx line not following serial bit");

   // request to send: raising causes
   a_rts_online: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (s_onl && !s_lv && !s_stb && !s_loc && !tx_valid && !rx_valid)
      |=> request_to_send)
      else $error("rts not raised");
   a_rts_turn_rx: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (st_q.line_opt && rx_act && rx_code != CODE_EOT && !tx_valid &&
       !s_lv && !s_stb && !s_loc &&
       (rx_code == st_q.turn_chr ||
        (st_q.dle_seen && rx_code == CODE_QMARK)))
      |=> request_to_send)
      else $error("rts not raised by received code");

   // request to send: dropping causes
   a_rts_drop: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (s_lv || s_stb || s_loc) |=> !request_to_send)
      else $error("rts not dropped");
   a_rts_eot: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (rx_act && rx_code == CODE_EOT && !st_q.eot_dis && !st_q.dle_seen)
      |=> !request_to_send)
      else $error("rts still on after eot");
   a_eot_strap: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (request_to_send && st_q.eot_dis && rx_act && rx_code == CODE_EOT &&
       !tx_valid && !s_lv && !s_stb && !s_loc)
      |=> request_to_send)
      else $error("rts dropped by eot while strapped off");
   a_rts_turn_tx: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (st_q.line_opt && tx_valid && tx_code == st_q.turn_chr)
      |=> !request_to_send)
      else $error("rts still on after sent turnaround");

   // ready lamp and clear masking
   a_lamp_int: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      s_int |=> !ready_lamp)
      else $error("lamp lit on interrupt");
   a_lamp_cts: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      !s_cts |=> !ready_lamp)
      else $error("lamp lit without clear");
   a_lamp_on: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (s_cts && !st_q.cts_mask && !s_int) |=> ready_lamp)
      else $error("lamp dark with clear on");
   a_cts_masked: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (st_q.line_opt && rx_act && rx_code == st_q.turn_chr)
      |=> ##1 !ready_lamp)
      else $error("clear not masked by turnaround");

   // terminal ready
   a_dtr_local: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (s_loc || !s_pwr) |=> !terminal_ready)
      else $error("dtr on in local");
   a_dtr_paper: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      st_q.paper_lat |=> !terminal_ready)
      else $error("dtr on after low paper");
   a_dtr_pulse: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      drop_start |=> !terminal_ready [*8])
      else $error("dtr drop too short");
   a_dtr_busy: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      drop_busy |=> !terminal_ready)
      else $error("dtr on during forced drop");
   a_dtr_on: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (s_pwr && !s_loc && !st_q.paper_lat && !drop_busy && !drop_start)
      |=> terminal_ready)
      else $error("dtr not on");

   // transparency
   a_transp_quiet: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      $rose(st_q.transp) |=> !print_en && !ctrl_en)
      else $error("print on in transparency");
   a_print_off: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      st_q.transp |=> !print_en && !ctrl_en)
      else $error("print or control on in transparency");
   a_transp_rts: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (st_q.transp && !s_onl) |=> !$rose(request_to_send))
      else $error("received code raised rts in transparency");
   a_tape_pass: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      rx_valid |=> tape_valid && tape_code == $past(rx_code))
      else $error("received code not passed to tape");
endmodule : mcl_top
`default_nettype wire

// file: dv/mcl_dataset_model.sv
/*
 mcl_dataset_model: behavioural dataset on the terminal's handshake lines.
 assumes request to send comes from the core clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module mcl_dataset_model (
   // clock
   input  wire logic core_clk,
   // handshake
   input  wire logic request_to_send,
   input  wire logic slow,
   output var  logic clear_to_send
);
   logic [3:0] wait_q = 4'h0;
   logic       cts_q  = 1'b0;

   assign clear_to_send = cts_q;

   // clear follows request after a settle delay
   always @(posedge core_clk) begin
      if (request_to_send == cts_q) begin
         wait_q <= 4'h0;
      end else if (wait_q >= (slow ? 4'h8 : 4'h1)) begin
         cts_q <= request_to_send;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule : mcl_dataset_model
`default_nettype wire

// file: dv/mcl_top_test.sv
/*
 mcl_top_test: self-checking bench for the modem control line logic.
 assumes mcl_pkg and the dataset model answering request to send.
*/
`timescale 1ns/1ns
`default_nettype none
module mcl_top_test
   import mcl_pkg::*;
;
   localparam int unsigned DROP = 20;
   logic       core_clk  = 1'b0;
   logic       sys_rst   = 1'b1;
   logic [3:0] reg_addr  = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr    = 1'b0;
   logic       reg_rd    = 1'b0;
   logic [6:0] pnl       = 7'h10;
   logic       rx_valid  = 1'b0;
   logic [6:0] rx_code   = 7'h00;
   logic       tx_valid  = 1'b0;
   logic [6:0] tx_code   = 7'h00;
   logic       tx_serial = 1'b1;
   logic       slow      = 1'b0;
   logic [7:0] reg_rdata;
   logic [6:0] tape_code;
   logic       cts, tx_line, rts, dtr, lamp, print_en, ctrl_en, tape_valid;
   int         err_count = 0;
   int         cmp_count = 0;

   always #5 core_clk = ~core_clk;

   mcl_top #(.DROP_CYC(DROP)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .btn_online(pnl[0]),
      .btn_standby(pnl[1]), .btn_local(pnl[2]), .low_voltage(pnl[3]),
      .power_ok(pnl[4]), .low_paper(pnl[5]), .interrupt_lamp(pnl[6]),
      .clear_to_send(cts), .rx_valid(rx_valid), .rx_code(rx_code),
      .tx_valid(tx_valid), .tx_code(tx_code), .tx_serial(tx_serial),
      .tx_line(tx_line), .request_to_send(rts), .terminal_ready(dtr),
      .ready_lamp(lamp), .print_en(print_en), .ctrl_en(ctrl_en),
      .tape_valid(tape_valid), .tape_code(tape_code));

   mcl_dataset_model partner (.core_clk(core_clk), .request_to_send(rts),
      .slow(slow), .clear_to_send(cts));

   task automatic conclude();
      if (err_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic settle();
      repeat (16) @(posedge core_clk);
      #1;
   endtask : settle

   task automatic pset(input int i, input logic v);
      @(posedge core_clk);
      pnl[i] <= v;
      settle();
   endtask : pset

   task automatic press(input int i);
      pset(i, 1'b1);
      pset(i, 1'b0);
   endtask : press

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask : rd

   // single code, returns just after the taking edge
   task automatic rx(input logic [6:0] c);
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_code  <= c;
      @(posedge core_clk);
      rx_valid <= 1'b0;
      #1;
   endtask : rx

   task automatic rx2(input logic [6:0] a, input logic [6:0] b);
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_code  <= a;
      @(posedge core_clk);
      rx_code <= b;
      @(posedge core_clk);
      rx_valid <= 1'b0;
   endtask : rx2

   task automatic t_reset();
      chk(tx_line, 1'b1);
      chk(rts, 1'b0);
      chk(dtr, 1'b1);
      chk({print_en, ctrl_en}, 2'h3);
      rd(ADR_TURN, {1'b0, TURN_RST});
      rd(ADR_STAT, 8'h02);
      rd(4'hf, 8'h00);
   endtask : t_reset

   task automatic t_online();
      press(0);
      chk(rts, 1'b1);
      chk(lamp, 1'b1);
      pset(6, 1'b1);
      chk(lamp, 1'b0);
      pset(6, 1'b0);
   endtask : t_online

   task automatic t_drop();
      for (int i = 1; i < 4; i++) begin
         press(0);
         pset(i, 1'b1);
         chk(rts, 1'b0);
         if (i == 2) chk(dtr, 1'b0);
         pset(i, 1'b0);
         chk(dtr, 1'b1);
      end
   endtask : t_drop

   task automatic t_eot();
      press(0);
      rx(CODE_EOT);
      settle();
      chk(rts, 1'b0);
      wr(ADR_CTRL, 8'h02);
      rd(ADR_CTRL, 8'h02);
      press(0);
      rx(CODE_EOT);
      settle();
      chk(rts, 1'b1);
   endtask : t_eot

   task automatic t_line();
      int n;
      n = 0;
      wr(ADR_CTRL, 8'h01);
      wr(ADR_TURN, 8'h2a);
      press(1);
      rx2(CODE_DLE, CODE_QMARK);
      settle();
      chk(rts, 1'b1);
      chk(lamp, 1'b1);
      rx(7'h2a);
      settle();
      chk(lamp, 1'b0);
      @(posedge core_clk);
      tx_valid  <= 1'b1;
      tx_code   <= 7'h2a;
      tx_serial <= 1'b0;
      @(posedge core_clk);
      tx_valid  <= 1'b0;
      tx_serial <= 1'b1;
      #1;
      chk(rts, 1'b0);
      chk(tx_line, 1'b0);
      settle();
      chk(tx_line, 1'b1);
      rx2(CODE_DLE, CODE_EOT);
      for (int k = 0; k < 100; k++) begin
         #1;
         if (dtr === 1'b0) n++;
         else if (n > 0) break;
         @(posedge core_clk);
      end
      chk(n, DROP + 1);
      wr(ADR_CTRL, 8'h00);
   endtask : t_line

   task automatic t_transp();
      wr(ADR_CTRL, 8'h04);
      press(0);
      chk({print_en, ctrl_en}, 2'h0);
      rx(CODE_EOT);
      chk({tape_valid, tape_code}, {1'b1, CODE_EOT});
      settle();
      chk(rts, 1'b1);
      wr(ADR_CTRL, 8'h00);
   endtask : t_transp

   task automatic t_paper();
      slow <= 1'b1;
      pset(5, 1'b1);
      chk(dtr, 1'b1);
      pset(5, 1'b0);
      press(1);
      pset(5, 1'b1);
      chk(dtr, 1'b0);
      pset(5, 1'b0);
      chk(dtr, 1'b1);
      pset(4, 1'b0);
      chk(dtr, 1'b0);
   endtask : t_paper

   initial begin
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      settle();
      t_reset();
      t_online();
      t_drop();
      t_eot();
      t_line();
      t_transp();
      t_paper();
      conclude();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      conclude();
   end
endmodule : mcl_top_test
`default_nettype wire
